// File: spc_auto_mode.v
// Purpose: automatic transmit/receive/idle choice
// Assumes: flags already synchronised
// Notes:   combinational
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_auto_mode (
    // Current state
    input  wire [2:0] cur_state,
    // Detector flags
    input  wire       tx_stronger,
    input  wire       tx_speech,
    input  wire       rx_speech,
    input  wire       dial_tone,
    // Result
    output reg  [2:0] next_state,
    output reg        rx_monitor_off
);
    always @* begin
        rx_monitor_off = (cur_state == `SPC_ST_RX) && dial_tone; // RL20
        next_state     = cur_state;
        if (tx_speech || (rx_speech && !rx_monitor_off)) begin
            next_state = tx_stronger ? `SPC_ST_TX : `SPC_ST_RX; // RL17 RL18
        end else if (rx_monitor_off) begin
            next_state = `SPC_ST_RX; // RL20
        end else begin
            next_state = `SPC_ST_IDLE; // RL19
        end
    end
endmodule // spc_auto_mode

// File: spc_consts.vh
// Purpose: constants for the speakerphone serial control block
// Assumes: 10 MHz system clock
// Notes:   definitions only
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
// =========================================
// Control word fields
`define SPC_WORD_W        8
`define SPC_VOL_LSB       0
`define SPC_VOL_MSB       3
`define SPC_MUTE_BIT      4
`define SPC_RANGE_BIT     5
`define SPC_MODE_LO_BIT   6
`define SPC_MODE_HI_BIT   7
`define SPC_WORD_RST      8'h00
// =========================================
// Mode field codes
`define SPC_MODE_AUTO     2'h0
`define SPC_MODE_RX       2'h1
`define SPC_MODE_IDLE     2'h2
`define SPC_MODE_TX       2'h3
// =========================================
// Operating state codes (one-hot)
`define SPC_ST_IDLE       3'h1
`define SPC_ST_RX         3'h2
`define SPC_ST_TX         3'h4
// =========================================
// Volume applied outside receive mode
`define SPC_VOL_NEUTRAL   4'h0
`endif

// File: spc_host_model.sv
// Purpose: controller driving the serial control pins
// Assumes: called from the bench after a clk edge
// Notes:   serial clock stands low between words
`timescale 1ns/1ps
module spc_host_model (
    // System
    input  wire  clk,
    // Serial pins
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe_n
);
    logic busy;
    initial {ser_clk, ser_data, load_strobe_n, busy} = 4'h2;
    // Released data line churns
    always @(posedge clk)
        if (!busy)
            ser_data <= ~ser_data;
    // ========================================
    // One transfer of n bits
    task automatic send(input logic [7:0] w, input int half,
                        input bit late, input int n);
        @(posedge clk);
        busy <= 1'b1;
        load_strobe_n <= late;
        // Churn stops before the data line is taken over
        @(posedge clk);
        for (int i = 7; i > 7 - n; i--) begin
            ser_data <= w[i];
            repeat (half) @(posedge clk);
            ser_clk <= 1'b1;
            // Late strobe falls just after the rising edge
            repeat (late) @(posedge clk);
            load_strobe_n <= 1'b0;
            repeat (half) @(posedge clk);
            ser_clk <= 1'b0;
        end
        repeat (half) @(posedge clk);
        load_strobe_n <= 1'b1;
        busy <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // spc_host_model

// File: spc_serial_ctrl.v
// Purpose: serial control port and mode selection of a speakerphone
// Assumes: clk 10 MHz; serial clock at most 1 MHz, sampled by clk
// Notes:   all pin inputs pass two flops before use
//
// Operation
// RL1: Range bit zero selects wide attenuator swing, one selects narrow.
// RL2: Four-bit volume, zero loudest, all ones quietest, about 3 dB steps.
// RL3: Volume reaches attenuators only in receive mode.
// RL4: Mute bit one mutes microphone amplifier, zero runs it normally.
// RL5: Mode 00 runs automatic voice-activated switching.
// RL6: Mode 01 forces receive; volume stays effective.
// RL7: Mode 10 forces idle, 11 forces transmit, overriding automatic.
// RL8: Eight bits travel mode high bit first, volume low bit last.
// RL9: One data bit sampled per rising serial clock edge.
// RL10: Controller keeps serial clock at or below 1 MHz.
// RL11: Controller holds strobe low while eight bits are clocked.
// RL12: Shifted word takes effect on rising strobe.
// RL13: No address, framing or handshake; only eight strobed bits.
// RL14: Strobe may fall together with the first rising clock edge.
// RL15: Controller should keep strobe high when idle.
// RL16: After last bit, clock stops or strobe rises before next edge.
// RL17: Automatic mode uses comparator and noise monitors.
// RL18: Speech keeps transmit or receive, whichever side is stronger.
// RL19: No speech on either side allows idle.
// RL20: Dial tone in receive disables receive monitor, blocks idle.
// RL21: Power-on reset low clears control word until next load.
// RL22: Words loaded during power-on reset are discarded.
// RL23: Chip-off ignores the serial port.
// RL24: Leaving chip-off clears all eight control bits.
// RL25: Shift stage kept apart from applied word.
// RL26: Rising clock edges with strobe high and outside first edge ignored.
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_serial_ctrl (
    // System
    input  wire       clk,
    input  wire       rst_n,
    // Serial port pins
    input  wire       ser_clk,
    input  wire       ser_data,
    input  wire       load_strobe_n,
    // Reset and power pins
    input  wire       por_n,
    input  wire       chip_off,
    // Detector flags
    input  wire       tx_stronger,
    input  wire       tx_speech,
    input  wire       rx_speech,
    input  wire       dial_tone,
    // Controlled functions
    output reg  [3:0] volume_field,
    output reg        mic_mute_bit,
    output reg        range_select_bit,
    output reg        mode_field_high,
    output reg        mode_field_low,
    output reg        narrow_range,
    output reg  [3:0] rx_volume,
    output reg        mic_muted,
    output reg  [2:0] op_state,
    output reg        rx_monitor_off,
    output reg        powered_down
);
    // =========================================
    // Input synchronisers
    wire sclk_s;
    wire sdat_s;
    wire strb_s;
    wire por_s;
    wire off_s;

    spc_sync2 #(.RST_VAL(1'b0)) u_sclk (
        .clk(clk), .rst_n(rst_n), .d(ser_clk), .q(sclk_s));
    spc_sync2 #(.RST_VAL(1'b0)) u_sdat (
        .clk(clk), .rst_n(rst_n), .d(ser_data), .q(sdat_s));
    spc_sync2 #(.RST_VAL(1'b1)) u_strb (
        .clk(clk), .rst_n(rst_n), .d(load_strobe_n), .q(strb_s));
    spc_sync2 #(.RST_VAL(1'b0)) u_por (
        .clk(clk), .rst_n(rst_n), .d(por_n), .q(por_s));
    spc_sync2 #(.RST_VAL(1'b1)) u_off (
        .clk(clk), .rst_n(rst_n), .d(chip_off), .q(off_s));

    // =========================================
    // Detector flag synchronisers
    // Analog detector flags are asynchronous to clk as well
    wire tx_stronger_s;
    wire tx_speech_s;
    wire rx_speech_s;
    wire dial_tone_s;

    spc_sync2 #(.RST_VAL(1'b0)) u_cmp (
        .clk(clk), .rst_n(rst_n), .d(tx_stronger), .q(tx_stronger_s));
    spc_sync2 #(.RST_VAL(1'b0)) u_txs (
        .clk(clk), .rst_n(rst_n), .d(tx_speech), .q(tx_speech_s));
    spc_sync2 #(.RST_VAL(1'b0)) u_rxs (
        .clk(clk), .rst_n(rst_n), .d(rx_speech), .q(rx_speech_s));
    spc_sync2 #(.RST_VAL(1'b0)) u_dt (
        .clk(clk), .rst_n(rst_n), .d(dial_tone), .q(dial_tone_s));

    // =========================================
    // Edge detection
    reg  sclk_d_r;
    reg  strb_d_r;
    reg  off_d_r;
    reg  sdat_d_r;
    wire sclk_rise;
    wire strb_rise;
    wire off_fall;
    wire port_ok;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            strb_d_r <= 1'b1;
            off_d_r  <= 1'b1;
            sdat_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            strb_d_r <= strb_s;
            off_d_r  <= off_s;
            sdat_d_r <= sdat_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r; // RL9
    assign strb_rise = strb_s & ~strb_d_r;
    assign off_fall  = ~off_s & off_d_r;
    assign port_ok   = por_s & ~off_s; // RL22 RL23

    // =========================================
    // Shift stage
    // A first edge seen while the strobe is still high is held as
    // pending; it counts only if the strobe falls before the serial
    // clock falls again.
    reg  [7:0] shift_r;
    reg  [7:0] shift_nxt;
    reg  [3:0] cnt_r;
    reg  [3:0] cnt_nxt;
    reg        pend_r;
    reg        pend_nxt;
    reg        pend_bit_r;
    reg        pend_bit_nxt;

    always @* begin
        shift_nxt    = shift_r;
        cnt_nxt      = cnt_r;
        pend_nxt     = pend_r;
        pend_bit_nxt = pend_bit_r;
        if (!port_ok || strb_rise) begin
            cnt_nxt  = 4'h0;
            pend_nxt = 1'b0;
        end else if (!strb_s) begin
            if (pend_r) begin
                shift_nxt = {shift_r[6:0], pend_bit_r}; // RL14
                cnt_nxt   = 4'h1;
                pend_nxt  = 1'b0;
            end
            if (sclk_rise && cnt_nxt < 4'h8) begin
                shift_nxt = {shift_nxt[6:0], sdat_d_r}; // RL8 RL9
                cnt_nxt   = cnt_nxt + 4'h1;
            end
        end else begin
            if (!sclk_s) begin
                pend_nxt = 1'b0; // RL26
            end
            if (sclk_rise && cnt_r == 4'h0) begin
                pend_nxt     = 1'b1; // RL14
                pend_bit_nxt = sdat_d_r;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r    <= `SPC_WORD_RST;
            cnt_r      <= 4'h0;
            pend_r     <= 1'b0;
            pend_bit_r <= 1'b0;
        end else begin
            shift_r    <= shift_nxt; // RL25
            cnt_r      <= cnt_nxt;
            pend_r     <= pend_nxt;
            pend_bit_r <= pend_bit_nxt;
        end
    end

    // =========================================
    // Applied control word
    reg  [7:0] word_r;
    reg  [7:0] word_nxt;

    always @* begin
        word_nxt = word_r;
        // Clear wins over a load in the same cycle
        if (!por_s || off_fall) begin
            word_nxt = `SPC_WORD_RST; // RL21 RL24
        end else if (port_ok && strb_rise && cnt_r == 4'h8) begin
            word_nxt = shift_r; // RL12 RL13
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_r <= `SPC_WORD_RST;
        end else begin
            word_r <= word_nxt;
        end
    end

    // =========================================
    // Decode helpers
    // Chip-off overrides whatever the mode field asks for
    function [2:0] pick_state;
        input [1:0] mode;
        input [2:0] auto_st;
        input       off;
        begin
            case (mode)
                `SPC_MODE_AUTO: pick_state = auto_st; // RL5
                `SPC_MODE_RX:   pick_state = `SPC_ST_RX; // RL6
                `SPC_MODE_IDLE: pick_state = `SPC_ST_IDLE; // RL7
                `SPC_MODE_TX:   pick_state = `SPC_ST_TX; // RL7
                default:        pick_state = `SPC_ST_IDLE;
            endcase
            if (off) begin
                pick_state = `SPC_ST_IDLE;
            end
        end
    endfunction

    // Attenuators see the volume only in the receive state
    function [3:0] gate_vol;
        input [2:0] st;
        input [7:0] wd;
        begin
            if (st == `SPC_ST_RX) begin
                gate_vol = wd[`SPC_VOL_MSB:`SPC_VOL_LSB];
            end else begin
                gate_vol = `SPC_VOL_NEUTRAL;
            end
        end
    endfunction

    // =========================================
    // Mode selection
    wire [1:0] mode_sel;
    wire [2:0] auto_state;
    wire       auto_mon_off;
    reg  [2:0] state_r;
    reg  [2:0] state_nxt;

    // Next word, so op_state moves together with the word outputs
    assign mode_sel = {word_nxt[`SPC_MODE_HI_BIT],
                       word_nxt[`SPC_MODE_LO_BIT]};

    spc_auto_mode u_auto (
        .cur_state     (state_r),
        .tx_stronger   (tx_stronger_s),
        .tx_speech     (tx_speech_s),
        .rx_speech     (rx_speech_s),
        .dial_tone     (dial_tone_s),
        .next_state    (auto_state),
        .rx_monitor_off(auto_mon_off)
    );

    always @* begin
        state_nxt = pick_state(mode_sel, auto_state, off_s); // RL5 RL6 RL7
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `SPC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // =========================================
    // Registered outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            volume_field     <= 4'h0;
            mic_mute_bit     <= 1'b0;
            range_select_bit <= 1'b0;
            mode_field_high  <= 1'b0;
            mode_field_low   <= 1'b0;
            narrow_range     <= 1'b0;
            rx_volume        <= `SPC_VOL_NEUTRAL;
            mic_muted        <= 1'b0;
            op_state         <= `SPC_ST_IDLE;
            rx_monitor_off   <= 1'b0;
            powered_down     <= 1'b1;
        end else begin
            volume_field     <= word_nxt[`SPC_VOL_MSB:`SPC_VOL_LSB]; // RL2
            mic_mute_bit     <= word_nxt[`SPC_MUTE_BIT];
            range_select_bit <= word_nxt[`SPC_RANGE_BIT];
            mode_field_high  <= word_nxt[`SPC_MODE_HI_BIT];
            mode_field_low   <= word_nxt[`SPC_MODE_LO_BIT];
            narrow_range     <= word_nxt[`SPC_RANGE_BIT]; // RL1
            mic_muted        <= word_nxt[`SPC_MUTE_BIT]; // RL4
            rx_volume        <= gate_vol(state_nxt, word_nxt); // RL3 RL6
            op_state         <= state_nxt;
            rx_monitor_off   <= (mode_sel == `SPC_MODE_AUTO) &&
                auto_mon_off; // RL20
            powered_down     <= off_s;
        end
    end
endmodule // spc_serial_ctrl

// File: spc_sva.sv
// Purpose: checker for the serial control block ports
// Assumes: bound by name onto spc_serial_ctrl
// Notes:   single clock domain
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_sva (
    // System
    input wire       clk,
    input wire       rst_n,
    // Pins
    input wire       load_strobe_n,
    input wire       por_n,
    input wire       tx_stronger,
    input wire       tx_speech,
    // Outputs
    input wire [3:0] volume_field,
    input wire       mic_mute_bit,
    input wire       range_select_bit,
    input wire       mode_field_high,
    input wire       mode_field_low,
    input wire       narrow_range,
    input wire [3:0] rx_volume,
    input wire       mic_muted,
    input wire [2:0] op_state,
    input wire       powered_down
);
    // ========================================
    // Helpers
    wire [7:0] word = {mode_field_high, mode_field_low, range_select_bit,
                       mic_mute_bit, volume_field};
    wire [1:0] mode = word[7:6];
    wire       live = !powered_down;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence por_held;
        !por_n [*5];
    endsequence
    sequence tx_talk;
        (mode == 2'h0 && live && tx_speech && tx_stronger) [*4];
    endsequence
    // ========================================
    // Properties
    a_range_map: assert property (narrow_range == range_select_bit)
        else $error("range output differs from word");
    a_mute_map: assert property (mic_muted == mic_mute_bit)
        else $error("mute output differs from word");
    a_vol_gate: assert property (rx_volume ==
        ((op_state == `SPC_ST_RX) ? volume_field : 4'h0))
        else $error("volume leaks outside receive");
    a_force_rx: assert property (mode == 2'h1 && live && $past(live)
        |-> op_state == `SPC_ST_RX) else $error("forced receive lost");
    a_force_idle: assert property (mode == 2'h2
        |-> op_state == `SPC_ST_IDLE) else $error("forced idle lost");
    a_force_tx: assert property (mode == 2'h3 && live && $past(live)
        |-> op_state == `SPC_ST_TX) else $error("forced transmit lost");
    a_auto_talk: assert property (tx_talk
        |=> op_state == `SPC_ST_TX || mode != 2'h0 || !live)
        else $error("auto mode missed transmit");
    a_word_load: assert property ($changed(word) && word != 8'h00
        |-> $past(load_strobe_n) && !$past(load_strobe_n, 6))
        else $error("word changed without strobe rise");
    a_por_clear: assert property (por_held |-> word == 8'h00)
        else $error("word kept during power-on reset");
    a_off_idle: assert property (powered_down [*2]
        |-> op_state == `SPC_ST_IDLE) else $error("active while off");
    a_wake_clear: assert property ($fell(powered_down)
        |-> ##[0:1] word == 8'h00) else $error("word kept after wake");
endmodule // spc_sva

// File: spc_sync2.v
// Purpose: two-flop synchroniser for one pin input
// Assumes: asynchronous input
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module spc_sync2 #(
    parameter RST_VAL = 1'b0
) (
    // System
    input  wire clk,
    input  wire rst_n,
    // Data
    input  wire d,
    output wire q
);
    reg meta_r;
    reg sync_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule // spc_sync2

// File: speakerphone_serial_control_tb_top.sv
// Purpose: self-checking bench for spc_serial_ctrl
// Assumes: 100 ns clock, link half period 5 or 8 clocks
// Notes:   seed fixed at 4751
`timescale 1ns/1ps
`include "spc_consts.vh"
module speakerphone_serial_control_tb_top;
    logic       clk, rst_n, por_n, chip_off;
    logic       tx_stronger, tx_speech, rx_speech, dial_tone;
    logic [7:0] w;
    logic [3:0] f;
    wire        ser_clk, ser_data, load_strobe_n;
    wire  [3:0] volume_field, rx_volume;
    wire        mic_mute_bit, range_select_bit, narrow_range, mic_muted;
    wire        mode_field_high, mode_field_low;
    wire        rx_monitor_off, powered_down;
    wire  [2:0] op_state;
    wire  [7:0] word = {mode_field_high, mode_field_low, range_select_bit,
                        mic_mute_bit, volume_field};
    int         bad_count, check_count;

    spc_serial_ctrl dut (
        .clk             (clk),
        .rst_n           (rst_n),
        .ser_clk         (ser_clk),
        .ser_data        (ser_data),
        .load_strobe_n   (load_strobe_n),
        .por_n           (por_n),
        .chip_off        (chip_off),
        .tx_stronger     (tx_stronger),
        .tx_speech       (tx_speech),
        .rx_speech       (rx_speech),
        .dial_tone       (dial_tone),
        .volume_field    (volume_field),
        .mic_mute_bit    (mic_mute_bit),
        .range_select_bit(range_select_bit),
        .mode_field_high (mode_field_high),
        .mode_field_low  (mode_field_low),
        .narrow_range    (narrow_range),
        .rx_volume       (rx_volume),
        .mic_muted       (mic_muted),
        .op_state        (op_state),
        .rx_monitor_off  (rx_monitor_off),
        .powered_down    (powered_down)
    );
    spc_host_model host (
        .clk          (clk),
        .ser_clk      (ser_clk),
        .ser_data     (ser_data),
        .load_strobe_n(load_strobe_n)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ========================================
    // Helpers
    function automatic logic [2:0] exp_state(logic [7:0] v);
        case (v[7:6])
            2'h1: return `SPC_ST_RX;
            2'h2: return `SPC_ST_IDLE;
            2'h3: return `SPC_ST_TX;
            default: return !(tx_speech || rx_speech) ? `SPC_ST_IDLE :
                            tx_stronger ? `SPC_ST_TX : `SPC_ST_RX;
        endcase
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic load(logic [7:0] v, int n);
        // Half period of 5 or 8 clocks keeps the link at or below 1 MHz
        host.send(v, 5 + 3 * $urandom_range(1),
                  $urandom_range(1), n);
        repeat (6) @(posedge clk);
    endtask
    task automatic set_flags(logic [3:0] v);
        @(posedge clk);
        {tx_stronger, tx_speech, rx_speech, dial_tone} <= v;
        repeat (6) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ========================================
    // Scenarios
    initial begin
        void'($urandom(4751));
        {rst_n, por_n, chip_off} = 3'b010;
        {tx_stronger, tx_speech, rx_speech, dial_tone} = 4'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(word, `SPC_WORD_RST);
        for (int i = 0; i < 16; i++) begin
            f = 4'($urandom);
            set_flags(f & 4'he);
            w = (i < 4) ? {i[1:0], 6'h35} : 8'($urandom);
            load(w, 8);
            chk(word, w);
            chk({narrow_range, mic_muted}, w[5:4]);
            chk(op_state, exp_state(w));
            chk(rx_volume, (exp_state(w) == `SPC_ST_RX) ? w[3:0] : 4'h0);
        end
        load(w ^ 8'h5a, 5);
        chk(word, w);
        set_flags(4'h0);
        load(8'h07, 8);
        set_flags(4'h2);
        chk(op_state, `SPC_ST_RX);
        set_flags(4'h1);
        chk(op_state, `SPC_ST_RX);
        chk(rx_monitor_off, 1'b1);
        chk(rx_volume, 4'h7);
        set_flags(4'h0);
        chk(op_state, `SPC_ST_IDLE);
        por_n <= 1'b0;
        // Release mid-word: bits shifted during reset must not count
        fork
            load(8'hc3, 8);
            begin
                repeat (12) @(posedge clk);
                por_n <= 1'b1;
            end
        join
        chk(word, 8'h00);
        load(8'h7c, 8);
        chk(op_state, `SPC_ST_RX);
        chip_off <= 1'b1;
        repeat (6) @(posedge clk);
        load(8'h81, 8);
        chk(word, 8'h7c);
        chk(op_state, `SPC_ST_IDLE);
        chk(powered_down, 1'b1);
        chip_off <= 1'b0;
        repeat (6) @(posedge clk);
        chk(word, 8'h00);
        chk(powered_down, 1'b0);
        finish_test();
    end
    // Hang guard
    initial begin
        #5000000;
        bad_count++;
        finish_test();
    end
endmodule // speakerphone_serial_control_tb_top

bind spc_serial_ctrl spc_sva chk_i (
    .clk(clk), .rst_n(rst_n), .load_strobe_n(load_strobe_n), .por_n(por_n),
    .tx_stronger(tx_stronger), .tx_speech(tx_speech),
    .volume_field(volume_field), .mic_mute_bit(mic_mute_bit),
    .range_select_bit(range_select_bit), .mode_field_high(mode_field_high),
    .mode_field_low(mode_field_low), .narrow_range(narrow_range),
    .rx_volume(rx_volume), .mic_muted(mic_muted), .op_state(op_state),
    .powered_down(powered_down));
